// file: hw/usb_core_pkg.sv
// Purpose: Shared constants for the USB core address, power and endpoint interrupt logic
// Assumes: AHB-Lite register access, one word per register
// Notes: Offsets are byte addresses
package usb_core_pkg;
	localparam logic [7:0] OFF_FUNC_ADDR = 8'h00;
	localparam logic [7:0] OFF_POWER = 8'h04;
	localparam logic [7:0] OFF_TX_IRQ = 8'h08;
	localparam logic [7:0] OFF_RX_IRQ = 8'h0C;
	localparam logic [7:0] OFF_DEV_CTRL = 8'h10;
	localparam logic [7:0] OFF_USB_IRQ = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFF_TX_MASK = 8'h1C;
	localparam logic [7:0] OFF_RX_MASK = 8'h20;

	// Power control field positions, and the mode bit of device control
	localparam int P_ISO = 7;
	localparam int P_SOFT_CONNECT = 6;
	localparam int P_HIGH_SPEED_ENABLE = 5;
	localparam int P_HSACT = 4;
	localparam int P_RESET = 3;
	localparam int P_RESUME = 2;
	localparam int P_SUSP = 1;
	localparam int P_SUSPOE = 0;
	localparam int DC_MODE = 2;

	// Common event bits of the block's own status register
	localparam int EV_SUSPEND = 0;
	localparam int EV_RESUME = 1;
	localparam int EV_RESET = 2;
	localparam int EV_SOF = 3;
	localparam int EV_HS_DONE = 4;

	localparam logic [7:0] POWER_RESET = 8'h20;
	localparam logic [7:0] FUNCTION_ADDRESS_RESET = 8'h00;
	localparam logic [4:0] TX_VALID_MASK = 5'h1F;
	localparam logic [4:0] RX_VALID_MASK = 5'h1E;
	localparam logic [4:0] EVT_VALID_MASK = 5'h1F;
	localparam logic [4:0] MASK_RESET = 5'h00;
endpackage

// file: hw/usb_flag_bank.sv
// Purpose: Sticky endpoint flags, cleared on read, set wins over clear
// Assumes: Read strobe is one cycle wide
// Notes: Read data comes from a register
`timescale 1ns/10ps
module usb_flag_bank
	import usb_core_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [4:0] set_in,
	input wire logic [4:0] valid,
	input wire logic rd,
	output logic [4:0] flags,
	output logic [4:0] rdata
);
	typedef struct packed {
		logic [4:0] flag;
		logic [4:0] rd;
	} state_type;
	state_type s_q, s_d;

	always_comb begin
		s_d = s_q;
		// Snapshot first, then clear what was seen; new events survive
		if (rd) begin
			s_d.rd = s_q.flag;
			s_d.flag = 5'h00;
		end
		s_d.flag = (s_d.flag | set_in) & valid;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign flags = s_q.flag;
	assign rdata = s_q.rd;
endmodule

// file: hw/usb_core_ctrl.sv
// Purpose: Function address, power management and endpoint interrupt status
// Assumes: Link events arrive as one-cycle pulses synchronous to CLK
// Notes on behaviour
// - Mode bit selects peripheral or host role
// - Peripheral compares token address with field
// - Iso update holds ready packet until SOF, peripheral role only
// - IN before SOF answers zero length
// - Soft connect drives or floats D lines
// - High speed enable allows negotiation
// - High speed status set on negotiation success
// - Reset bit shows bus reset, host writable
// - Host sets resume on remote wakeup
// - Suspend set by host software or peripheral
// - Suspend clears on interrupt read or resume
// - Suspend output gated by enable bit
// - Tx status bits 0-4, rest zero
// - Rx status bits 1-4, others zero
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module usb_core_ctrl
	import usb_core_pkg::*;
(
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic CE,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [7:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic HREADY,
	input wire logic [31:0] HWDATA,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic IRQ,
	// Link events from the protocol engine
	input wire logic TOKEN_VALID,
	input wire logic [6:0] TOKEN_ADDR,
	input wire logic TOKEN_IN,
	input wire logic TOKEN_ISO,
	input wire logic SOF_SEEN,
	input wire logic BUS_RESET,
	input wire logic SUSPEND_SEEN,
	input wire logic RESUME_SEEN,
	input wire logic HS_NEG_OK,
	input wire logic TX_PKT_READY,
	input wire logic [4:0] TX_EP_EVENT,
	input wire logic [4:0] RX_EP_EVENT,
	input wire logic SOFT_CONN_AVAIL,
	// Link controls
	output logic ADDR_MATCH,
	output logic HOST_MODE,
	output logic [6:0] TARGET_ADDR,
	output logic TX_SEND,
	output logic TX_ZERO_LEN,
	output logic HS_NEG_EN,
	output logic DRIVE_RESET,
	output logic DRIVE_RESUME,
	output logic LINE_OE,
	output logic SUSPEND_N_OUT
);
	typedef enum logic [1:0] {
		ISO_IDLE = 2'b01,
		ISO_WAIT = 2'b10
	} iso_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] power;
		logic [7:0] dev_ctrl;
		logic [4:0] evt;
		logic [4:0] evt_mask;
		logic [4:0] tx_mask;
		logic [4:0] rx_mask;
		iso_type iso;
		logic dp_act;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
		logic addr_match;
		logic tx_send;
		logic tx_zero;
	} state_type;

	state_type s_q, s_d;
	logic [4:0] tx_flags, rx_flags, tx_rd, rx_rd;
	logic tx_read, rx_read, addr_ok, host, rd_usb;

	function automatic logic [31:0] w8(input logic [7:0] v);
		w8 = {24'h00_0000, v};
	endfunction

	function automatic logic [31:0] w5(input logic [4:0] v);
		w5 = {27'h000_0000, v};
	endfunction

	assign addr_ok = HSEL && HREADY && HTRANS[1];
	assign host = s_q.dev_ctrl[DC_MODE];
	// Clear-on-read snapshots are taken at the address phase
	assign tx_read = addr_ok && !HWRITE && HADDR == OFF_TX_IRQ;
	assign rx_read = addr_ok && !HWRITE && HADDR == OFF_RX_IRQ;
	assign rd_usb = addr_ok && !HWRITE && HADDR == OFF_USB_IRQ;

	usb_flag_bank tx_bank (
		.clk(CLK),
		.arst_n(ARST_N),
		.ce(CE),
		.set_in(TX_EP_EVENT),
		.valid(TX_VALID_MASK),
		.rd(tx_read),
		.flags(tx_flags),
		.rdata(tx_rd)
	);

	usb_flag_bank rx_bank (
		.clk(CLK),
		.arst_n(ARST_N),
		.ce(CE),
		.set_in(RX_EP_EVENT),
		.valid(RX_VALID_MASK),
		.rd(rx_read),
		.flags(rx_flags),
		.rdata(rx_rd)
	);

	always_comb begin
		logic [7:0] wd;
		logic [4:0] ev;
		wd = HWDATA[7:0];
		ev = 5'h00;
		s_d = s_q;
		s_d.addr_match = 1'b0;
		s_d.tx_send = 1'b0;
		s_d.tx_zero = 1'b0;

		// Register writes, data phase
		if (s_q.dp_act && s_q.dp_wr) begin
			case (s_q.dp_addr)
				OFF_FUNC_ADDR: s_d.addr = {1'b0, wd[6:0]};
				OFF_POWER: begin
					s_d.power[P_ISO] = wd[P_ISO];
					s_d.power[P_SOFT_CONNECT] = wd[P_SOFT_CONNECT];
					s_d.power[P_HIGH_SPEED_ENABLE] = wd[P_HIGH_SPEED_ENABLE];
					s_d.power[P_RESUME] = wd[P_RESUME];
					s_d.power[P_SUSPOE] = wd[P_SUSPOE];
					if (host) begin
						s_d.power[P_RESET] = wd[P_RESET];
						s_d.power[P_SUSP] = wd[P_SUSP];
					end
				end
				OFF_DEV_CTRL: s_d.dev_ctrl = wd;
				OFF_USB_IRQ: s_d.evt = s_q.evt & ~wd[4:0];
				OFF_IRQ_MASK: s_d.evt_mask = wd[4:0];
				OFF_TX_MASK: s_d.tx_mask = wd[4:0] & TX_VALID_MASK;
				OFF_RX_MASK: s_d.rx_mask = wd[4:0] & RX_VALID_MASK;
				default: ;
			endcase
		end

		// Hardware status
		if (!host) begin
			s_d.power[P_RESET] = BUS_RESET;
			if (SUSPEND_SEEN) begin
				s_d.power[P_SUSP] = 1'b1;
			end
		end else if (RESUME_SEEN && s_q.power[P_SUSP]) begin
			s_d.power[P_RESUME] = 1'b1;
		end
		if (HS_NEG_OK && s_q.power[P_HIGH_SPEED_ENABLE]) begin
			s_d.power[P_HSACT] = 1'b1;
		end else if (!s_q.power[P_HIGH_SPEED_ENABLE]) begin
			s_d.power[P_HSACT] = 1'b0;
		end
		if (rd_usb || s_d.power[P_RESUME]) begin
			s_d.power[P_SUSP] = 1'b0;
		end

		// Token decode in peripheral role
		if (TOKEN_VALID && !host) begin
			s_d.addr_match = TOKEN_ADDR == s_q.addr[6:0];
		end

		// Isochronous transmit gating
		case (s_q.iso)
			ISO_IDLE: begin
				if (TX_PKT_READY) begin
					if (s_q.power[P_ISO] && !host) begin
						s_d.iso = ISO_WAIT;
					end else begin
						s_d.tx_send = 1'b1;
					end
				end
			end
			ISO_WAIT: begin
				if (SOF_SEEN) begin
					s_d.tx_send = 1'b1;
					s_d.iso = ISO_IDLE;
				end else if (TOKEN_VALID && TOKEN_IN && TOKEN_ISO) begin
					s_d.tx_zero = 1'b1;
				end
			end
			default: s_d.iso = ISO_IDLE;
		endcase

		// Sticky events; write-one clear loses to a new event
		ev[EV_SUSPEND] = SUSPEND_SEEN;
		ev[EV_RESUME] = RESUME_SEEN;
		ev[EV_RESET] = BUS_RESET;
		ev[EV_SOF] = SOF_SEEN;
		ev[EV_HS_DONE] = HS_NEG_OK;
		s_d.evt = (s_d.evt | ev) & EVT_VALID_MASK;

		// Bus address phase capture and read data
		if (HREADY) begin
			s_d.dp_act = addr_ok;
			s_d.dp_wr = HWRITE;
			s_d.dp_addr = HADDR;
		end
		if (addr_ok && !HWRITE) begin
			case (HADDR)
				OFF_FUNC_ADDR: s_d.rdata = w8(s_q.addr);
				OFF_POWER: s_d.rdata = w8(s_q.power);
				OFF_DEV_CTRL: s_d.rdata = w8(s_q.dev_ctrl);
				OFF_USB_IRQ: s_d.rdata = w5(s_q.evt);
				OFF_IRQ_MASK: s_d.rdata = w5(s_q.evt_mask);
				OFF_TX_MASK: s_d.rdata = w5(s_q.tx_mask);
				OFF_RX_MASK: s_d.rdata = w5(s_q.rx_mask);
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s_q <= '{addr: FUNCTION_ADDRESS_RESET, power: POWER_RESET, dev_ctrl: 8'h00,
				evt: MASK_RESET, evt_mask: MASK_RESET, tx_mask: MASK_RESET,
				rx_mask: MASK_RESET, iso: ISO_IDLE, dp_act: 1'b0, dp_wr: 1'b0,
				dp_addr: 8'h00, rdata: 32'h0000_0000, addr_match: 1'b0,
				tx_send: 1'b0, tx_zero: 1'b0};
		end else if (CE) begin
			s_q <= s_d;
		end
	end

	// Endpoint status reads come from the flag bank's own registered snapshot
	always_comb begin
		HRDATA = s_q.rdata;
		if (s_q.dp_act && !s_q.dp_wr) begin
			if (s_q.dp_addr == OFF_TX_IRQ) begin
				HRDATA = w5(tx_rd);
			end else if (s_q.dp_addr == OFF_RX_IRQ) begin
				HRDATA = w5(rx_rd);
			end
		end
	end

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign IRQ = |(s_q.evt & s_q.evt_mask) | |(tx_flags & s_q.tx_mask) |
		|(rx_flags & s_q.rx_mask);
	assign ADDR_MATCH = s_q.addr_match;
	assign HOST_MODE = host;
	assign TARGET_ADDR = s_q.addr[6:0];
	assign TX_SEND = s_q.tx_send;
	assign TX_ZERO_LEN = s_q.tx_zero;
	assign HS_NEG_EN = s_q.power[P_HIGH_SPEED_ENABLE];
	assign DRIVE_RESET = host && s_q.power[P_RESET];
	assign DRIVE_RESUME = s_q.power[P_RESUME];
	// Without soft connect the lines stay driven by the role logic
	assign LINE_OE = host || !SOFT_CONN_AVAIL || s_q.power[P_SOFT_CONNECT];
	assign SUSPEND_N_OUT = !(s_q.power[P_SUSPOE] && s_q.power[P_SUSP]);
endmodule

// file: testbench/usb_core_ctrl_assertions.sv
// Purpose: Port checks of match, send, line enable, status reads
// Assumes: CE held high
// Notes: Bound into every core instance
`timescale 1ns/10ps
module usb_core_checker
	import usb_core_pkg::*;
(
	// Clock, reset
	input wire logic CLK,
	input wire logic ARST_N,
	// Bus
	input wire logic HSEL,
	input wire logic [7:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	// Link
	input wire logic TOKEN_VALID,
	input wire logic [6:0] TOKEN_ADDR,
	input wire logic TOKEN_IN,
	input wire logic TOKEN_ISO,
	input wire logic SOF_SEEN,
	input wire logic TX_PKT_READY,
	input wire logic SOFT_CONN_AVAIL,
	input wire logic ADDR_MATCH,
	input wire logic HOST_MODE,
	input wire logic [6:0] TARGET_ADDR,
	input wire logic TX_SEND,
	input wire logic TX_ZERO_LEN,
	input wire logic DRIVE_RESET,
	input wire logic LINE_OE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	wire hit = TOKEN_VALID && !HOST_MODE && TOKEN_ADDR == TARGET_ADDR;
	wire cause = TX_PKT_READY || SOF_SEEN;
	wire iso_in = TOKEN_VALID && TOKEN_IN && TOKEN_ISO;
	wire rd_go = HSEL && HREADY && HTRANS[1] && !HWRITE;
	property p_match; hit |=> ADDR_MATCH; endproperty
	a_match: assert property (p_match) else $error("no match pulse");
	property p_no_match; ADDR_MATCH |-> $past(hit); endproperty
	a_no_match: assert property (p_no_match) else $error("spurious match");
	property p_send; TX_SEND |-> $past(cause); endproperty
	a_send: assert property (p_send) else $error("send without cause");
	property p_zero; TX_ZERO_LEN |-> $past(iso_in); endproperty
	a_zero: assert property (p_zero) else $error("zero length without token");
	property p_oe; HOST_MODE || !SOFT_CONN_AVAIL |-> LINE_OE; endproperty
	a_oe: assert property (p_oe) else $error("lines not driven");
	property p_drst; DRIVE_RESET |-> HOST_MODE; endproperty
	a_drst: assert property (p_drst) else $error("reset driven as peripheral");
	property p_tx_rd; rd_go && HADDR == OFF_TX_IRQ |=> HRDATA[31:5] == '0; endproperty
	a_tx_rd: assert property (p_tx_rd) else $error("tx status upper bits set");
	property p_rx_rd; rd_go && HADDR == OFF_RX_IRQ |=> HRDATA[31:5] == '0 && !HRDATA[0]; endproperty
	a_rx_rd: assert property (p_rx_rd) else $error("rx status reserved bits set");
endmodule
bind usb_core_ctrl usb_core_checker i_chk (.CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.TOKEN_VALID(TOKEN_VALID), .TOKEN_ADDR(TOKEN_ADDR), .TOKEN_IN(TOKEN_IN),
	.TOKEN_ISO(TOKEN_ISO), .SOF_SEEN(SOF_SEEN), .TX_PKT_READY(TX_PKT_READY),
	.SOFT_CONN_AVAIL(SOFT_CONN_AVAIL), .ADDR_MATCH(ADDR_MATCH), .HOST_MODE(HOST_MODE),
	.TARGET_ADDR(TARGET_ADDR), .TX_SEND(TX_SEND), .TX_ZERO_LEN(TX_ZERO_LEN),
	.DRIVE_RESET(DRIVE_RESET), .LINE_OE(LINE_OE));

// file: testbench/usb_bus_partner.sv
// Purpose: Bus partner issuing tokens and link events
// Assumes: One pulse per call, which may carry several events, one cycle wide
// Notes: Idle token lines show inverted last value, not a stale copy
`timescale 1ns/10ps
module usb_bus_partner (
	// Clock
	input wire logic clk,
	// Link events
	output logic tv,
	output logic [6:0] ta,
	output logic tin,
	output logic tiso,
	output logic brst,
	output logic [14:0] ev
);
	initial {tv, ta, tin, tiso, brst, ev} = '0;
	task token(input logic [6:0] a, input logic in, iso);
		tv <= 1'b1;
		{ta, tin, tiso} <= {a, in, iso};
		@(posedge clk);
		tv <= 1'b0;
		{ta, tin, tiso} <= ~{a, in, iso};
		#1;
	endtask
	// Bits: sof, suspend, resume, hs ok, tx ready, tx ep 4:0, rx ep 4:0
	task pulse(input logic [14:0] v);
		ev <= v;
		@(posedge clk);
		ev <= '0;
		#1;
	endtask
endmodule

// file: testbench/tb_usb_core_power_addr_irq.sv
// Purpose: Bench for address, power and endpoint interrupt block
// Assumes: One slave, hready looped back
// Notes: Link events come from the partner
`timescale 1ns/10ps
module tb_usb_core_power_addr_irq;
	import usb_core_pkg::*;
	logic clk = 0, arst_n = 0, hsel = 0, hwrite = 0, scon = 0, ce = 1;
	logic [2:0] hsize = 0;
	wire hresp;
	logic [7:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [31:0] hwdata = 0, rd;
	wire [31:0] hrdata;
	wire hready, irq, am, hm, txs, txz, hse, drst, dres, loe, sn, tv, tin, tiso, brst;
	wire [6:0] ta, taddr;
	wire [14:0] ev;
	int err_total = 0, checks = 0;
	always #10 clk = ~clk;
	usb_bus_partner partner (.clk(clk), .tv(tv), .ta(ta), .tin(tin), .tiso(tiso),
		.brst(brst), .ev(ev));
	usb_core_ctrl i_usb_core_ctrl (.CLK(clk), .ARST_N(arst_n), .CE(ce), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hready),
		.HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq),
		.TOKEN_VALID(tv), .TOKEN_ADDR(ta), .TOKEN_IN(tin), .TOKEN_ISO(tiso),
		.SOF_SEEN(ev[14]), .BUS_RESET(brst), .SUSPEND_SEEN(ev[13]), .RESUME_SEEN(ev[12]),
		.HS_NEG_OK(ev[11]), .TX_PKT_READY(ev[10]), .TX_EP_EVENT(ev[9:5]),
		.RX_EP_EVENT(ev[4:0]), .SOFT_CONN_AVAIL(scon), .ADDR_MATCH(am), .HOST_MODE(hm),
		.TARGET_ADDR(taddr), .TX_SEND(txs), .TX_ZERO_LEN(txz), .HS_NEG_EN(hse),
		.DRIVE_RESET(drst), .DRIVE_RESUME(dres), .LINE_OE(loe), .SUSPEND_N_OUT(sn));
	task chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Ends 1 ns past the edge so stored results have landed
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		haddr <= a;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		#1;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task t_regs;
		rdchk(OFF_POWER, POWER_RESET);
		rdchk(8'h40, 32'h0);
		chk(hresp, 32'h0);
		bus(1'b1, OFF_FUNC_ADDR, 32'hFFFF_FFFF);
		rdchk(OFF_FUNC_ADDR, 32'h7F);
		bus(1'b1, OFF_TX_IRQ, 32'hFFFF_FFFF);
		rdchk(OFF_TX_IRQ, 32'h0);
		bus(1'b1, OFF_FUNC_ADDR, 32'h2A);
		partner.token(7'h2A, 1'b0, 1'b0);
		chk(am, 32'h1);
		partner.token(7'h2B, 1'b0, 1'b0);
		chk(am, 32'h0);
		$display("register and address test done");
	endtask
	task t_iso;
		bus(1'b1, OFF_POWER, 32'hA0);
		partner.pulse(15'h0400);
		chk(txs, 32'h0);
		partner.token(7'h2A, 1'b1, 1'b1);
		chk(txz, 32'h1);
		partner.pulse(15'h4000);
		chk(txs, 32'h1);
		bus(1'b1, OFF_POWER, 32'h20);
		partner.pulse(15'h0400);
		chk(txs, 32'h1);
		@(posedge clk);
		#1;
		// Enable low: the ready pulse must be lost, no send follows
		ce <= 1'b0;
		partner.pulse(15'h0400);
		chk(txs, 32'h0);
		ce <= 1'b1;
		@(posedge clk);
		#1;
		chk(txs, 32'h0);
		$display("iso test done");
	endtask
	task t_irq;
		partner.pulse(15'h03FF);
		chk(irq, 32'h0);
		bus(1'b1, OFF_TX_MASK, 32'h1);
		chk(irq, 32'h1);
		rdchk(OFF_TX_IRQ, 32'h1F);
		chk(irq, 32'h0);
		rdchk(OFF_TX_IRQ, 32'h0);
		rdchk(OFF_RX_IRQ, 32'h1E);
		rdchk(OFF_RX_IRQ, 32'h0);
		bus(1'b1, OFF_IRQ_MASK, 32'h8);
		partner.pulse(15'h4000);
		chk(irq, 32'h1);
		bus(1'b1, OFF_USB_IRQ, 32'h8);
		chk(irq, 32'h0);
		$display("interrupt test done");
	endtask
	task t_host;
		bus(1'b1, OFF_DEV_CTRL, 32'h4);
		chk(hm, 32'h1);
		bus(1'b1, OFF_FUNC_ADDR, 32'h15);
		chk(taddr, 32'h15);
		bus(1'b1, OFF_POWER, 32'h2A);
		chk(drst, 32'h1);
		rdchk(OFF_POWER, 32'h2A);
		partner.pulse(15'h1000);
		rdchk(OFF_POWER, 32'h2C);
		chk(dres, 32'h1);
		bus(1'b1, OFF_POWER, 32'h20);
		chk(dres, 32'h0);
		bus(1'b1, OFF_DEV_CTRL, 32'h0);
		chk(drst, 32'h0);
		$display("host test done");
	endtask
	task t_power;
		scon <= 1'b1;
		bus(1'b1, OFF_POWER, 32'h20);
		chk(loe, 32'h0);
		bus(1'b1, OFF_POWER, 32'h60);
		chk(loe, 32'h1);
		chk(hse, 32'h1);
		partner.pulse(15'h0800);
		rdchk(OFF_POWER, 32'h70);
		partner.pulse(15'h2000);
		rdchk(OFF_POWER, 32'h72);
		chk(sn, 32'h1);
		bus(1'b1, OFF_POWER, 32'h61);
		chk(sn, 32'h0);
		bus(1'b0, OFF_USB_IRQ, 32'h0);
		rdchk(OFF_POWER, 32'h71);
		$display("power test done");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_iso;
		t_irq;
		t_host;
		t_power;
		tally_and_finish;
	end
	// Whole run is under a hundred cycles
	initial begin
		#100000;
		err_total++;
		tally_and_finish;
	end
endmodule
